// *** rtc_map_params.svh ***
// Constants for the paged clock/calendar register map.
// Assumes inclusion by the map module only.
`ifndef RTC_MAP_PARAMS_SVH
`define RTC_MAP_PARAMS_SVH

// ----------------------------------------
// Clocking
// ----------------------------------------
`define RTC_CLK_HZ 250000000
`define RTC_BASE_HZ 32768
`define RTC_TAP_1024 15'h001f
`define RTC_TAP_32 15'h03ff
`define RTC_TAP_1HZ 15'h7fff

// ----------------------------------------
// Addresses
// ----------------------------------------
`define RTC_MAIN_CTRL 6'h00
`define RTC_IRQ_EN 6'h01
`define RTC_IRQ_FLAG 6'h02
`define RTC_STATUS 6'h03
`define RTC_SYS_RESET 6'h04
`define RTC_SEC 6'h08
`define RTC_MIN 6'h09
`define RTC_HOUR 6'h0a
`define RTC_DAY 6'h0b
`define RTC_WDAY 6'h0c
`define RTC_MON 6'h0d
`define RTC_YEAR 6'h0e
`define RTC_AL_SEC 6'h10
`define RTC_AL_MIN 6'h11
`define RTC_AL_HOUR 6'h12
`define RTC_AL_DAY 6'h13
`define RTC_AL_WDAY 6'h14
`define RTC_AL_MON 6'h15
`define RTC_AL_YEAR 6'h16
`define RTC_TMR_LO 6'h18
`define RTC_TMR_HI 6'h19
`define RTC_TEMP 6'h20
`define RTC_NV_USER0 6'h28
`define RTC_NV_USER1 6'h29
`define RTC_NV_CTRL 6'h30
`define RTC_XTAL_OFS 6'h31
`define RTC_XTAL_COEF 6'h32
`define RTC_CRYSTAL_TURNOVER_TEMP 6'h33
`define RTC_RAM_PAGE 5'h07

// ----------------------------------------
// Implemented-bit masks
// ----------------------------------------
`define RTC_M_FULL 8'hff
`define RTC_M_IRQ 8'h1f
`define RTC_M_STAT 8'hbc
`define RTC_M_RST 8'h10
`define RTC_M_SEC 8'h7f
`define RTC_M_DAY 8'h3f
`define RTC_M_WDAY 8'h07
`define RTC_M_MON 8'h1f
`define RTC_M_AHR 8'hbf
`define RTC_M_AWD 8'h87
`define RTC_M_AMON 8'h9f

// ----------------------------------------
// Fields and values
// ----------------------------------------
`define RTC_B_WATCH 0
`define RTC_B_TMR_EN 1
`define RTC_B_TMR_AR 2
`define RTC_B_NV_REF 3
`define RTC_B_SELFREC 4
`define RTC_B_TSRC_LO 5
`define RTC_B_TSRC_HI 6
`define RTC_B_PINSEL 7
`define RTC_B_TF 1
`define RTC_B_FD_LO 2
`define RTC_B_FD_HI 3
`define RTC_RST_VAL 8'h00
`define RTC_BCD_NINE 4'h9
`define RTC_SEC_LAST 8'h59
`define RTC_HOUR_LAST 8'h23
`define RTC_WDAY_LAST 8'h06
`define RTC_MON_LAST 8'h12
`define RTC_YEAR_LAST 8'h99
`define RTC_FIRST_ONE 8'h01
`define RTC_FEB 8'h02
`define RTC_LEN_28 8'h28
`define RTC_LEN_29 8'h29
`define RTC_LEN_30 8'h30
`define RTC_LEN_31 8'h31

`endif

// *** rtc_map_pkg.sv ***
// Types shared by the paged register map.
// Assumes rtc_map_params.svh is on the include path.
package rtc_map_pkg;
    typedef enum logic [2:0] {
        XF_IDLE = 3'b001,
        XF_ADDR = 3'b010,
        XF_DATA = 3'b100
    } xfer_state_t;

    typedef enum logic [1:0] {
        SRC_32K = 2'b00,
        SRC_1K = 2'b01,
        SRC_32 = 2'b10,
        SRC_1HZ = 2'b11
    } tick_src_t;
endpackage : rtc_map_pkg

// *** rtc_paged_register_map.sv ***
// Paged register map of a clock/calendar: byte transfer port, watch
// counters, countdown timer, pin routing and control outputs.
// Assumes a serial front end that delivers whole bytes synchronous to
// clock_i and holds xfer_active_i high for the whole transfer.
`timescale 1ns/1ps
`include "rtc_map_params.svh"

module rtc_paged_register_map
    import rtc_map_pkg::*;
#(
    parameter int BASE_DIV = `RTC_CLK_HZ / `RTC_BASE_HZ
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic xfer_active_i,
    input wire logic addr_valid_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_valid_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_req_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic [7:0] temperature_i,
    input wire logic clock_output_pin_enable_i,
    output logic clock_output_pin_o,
    output logic clock_output_pin_oe_o,
    output logic self_recovery_enable_o,
    output logic nv_refresh_o
);

    // Prescaler count is only 16 bits wide
    if (BASE_DIV < 2 || BASE_DIV > 65535)
    begin : g_div_check
        $error("BASE_DIV out of range");
    end

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // zero unimplemented bits
    function automatic logic [7:0] impl_mask(input logic [7:0] a);
        logic [7:0] m;
        m = 8'h00;
        if (a[7:6] == 2'b00)
        begin
            case (a[5:0])
                `RTC_MAIN_CTRL, `RTC_AL_SEC, `RTC_AL_MIN,
                `RTC_AL_YEAR, `RTC_TMR_LO, `RTC_TMR_HI, `RTC_TEMP,
                `RTC_NV_USER0, `RTC_NV_USER1, `RTC_NV_CTRL,
                `RTC_XTAL_OFS, `RTC_XTAL_COEF: m = `RTC_M_FULL;
                `RTC_IRQ_EN, `RTC_IRQ_FLAG, `RTC_MON: m = `RTC_M_IRQ;
                `RTC_STATUS: m = `RTC_M_STAT;
                `RTC_SYS_RESET: m = `RTC_M_RST;
                `RTC_SEC, `RTC_MIN, `RTC_HOUR, `RTC_YEAR: m = `RTC_M_SEC;
                `RTC_DAY, `RTC_CRYSTAL_TURNOVER_TEMP: m = `RTC_M_DAY;
                `RTC_WDAY: m = `RTC_M_WDAY;
                `RTC_AL_HOUR, `RTC_AL_DAY: m = `RTC_M_AHR;
                `RTC_AL_WDAY: m = `RTC_M_AWD;
                `RTC_AL_MON: m = `RTC_M_AMON;
                default:
                begin
                    if (a[7:3] == `RTC_RAM_PAGE)
                        m = `RTC_M_FULL;
                end
            endcase
        end
        return m;
    endfunction : impl_mask

    // BCD step
    // Returns carry in bit 8; wraps to first after last.
    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
        input logic [7:0] last, input logic [7:0] first);
        logic [8:0] r;
        r = {1'b0, v};
        if (v >= last)
            r = {1'b1, first};
        else if (v[3:0] == `RTC_BCD_NINE)
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        else
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction : bcd_inc

    function automatic logic [7:0] month_len(input logic [7:0] mon,
        input logic [7:0] yr);
        logic leap;
        logic [7:0] len;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4
                        || yr[3:0] == 4'h8);
        case (mon)
            `RTC_FEB: len = leap ? `RTC_LEN_29 : `RTC_LEN_28;
            8'h04, 8'h06, 8'h09, 8'h11: len = `RTC_LEN_30;
            default: len = `RTC_LEN_31;
        endcase
        return len;
    endfunction : month_len

    function automatic logic tap(input logic [14:0] pre,
        input logic [14:0] m);
        return (pre & m) == m;
    endfunction : tap

    // ----------------------------------------
    // Time base
    // ----------------------------------------
    logic [15:0] base_cnt_q;
    logic [14:0] pre_q;
    logic base_tick;
    logic tick_1k;
    logic tick_32;
    logic tick_1hz;

    assign base_tick = base_cnt_q == 16'(BASE_DIV - 1);
    assign tick_1k = base_tick && tap(pre_q, `RTC_TAP_1024);
    assign tick_32 = base_tick && tap(pre_q, `RTC_TAP_32);
    assign tick_1hz = base_tick && tap(pre_q, `RTC_TAP_1HZ);

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            base_cnt_q <= 16'h0000;
            pre_q <= 15'h0000;
        end
        else if (base_tick)
        begin
            base_cnt_q <= 16'h0000;
            pre_q <= pre_q + 15'h0001;
        end
        else
        begin
            base_cnt_q <= base_cnt_q + 16'h0001;
        end
    end

    // ----------------------------------------
    // Transfer sequencing
    // ----------------------------------------
    xfer_state_t xf_q;
    logic [7:0] addr_q;
    logic do_wr;
    logic do_rd;

    assign do_wr = xf_q == XF_DATA && xfer_active_i && wr_valid_i;
    assign do_rd = xf_q == XF_DATA && xfer_active_i && rd_req_i;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            xf_q <= XF_IDLE;
            addr_q <= 8'h00;
        end
        else
        begin
            case (xf_q)
                XF_IDLE:
                begin
                    if (xfer_active_i)
                        xf_q <= XF_ADDR;
                end
                XF_ADDR:
                begin
                    if (!xfer_active_i)
                        xf_q <= XF_IDLE;
                    else if (addr_valid_i)
                    begin
                        xf_q <= XF_DATA;
                        addr_q <= addr_i;
                    end
                end
                XF_DATA:
                begin
                    if (!xfer_active_i)
                        xf_q <= XF_IDLE;
                    else if (do_wr || do_rd)
                        addr_q <= {addr_q[7:3], addr_q[2:0] + 3'h1};
                end
                default: xf_q <= XF_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Register store and watch counters
    // ----------------------------------------
    // eight pages, only mapped bits kept
    logic [7:0] regs_q [0:63];
    logic [7:0] ctrl;
    logic tick_pend_q;
    logic advance;
    logic tmr_zero;
    logic [8:0] sec_n;
    logic [8:0] min_n;
    logic [8:0] hour_n;
    logic [8:0] day_n;
    logic [8:0] wday_n;
    logic [8:0] mon_n;
    logic [8:0] year_n;

    assign ctrl = regs_q[`RTC_MAIN_CTRL];

    assign advance = ctrl[`RTC_B_WATCH] && !xfer_active_i
                     && (tick_1hz || tick_pend_q);

    always_comb
    begin
        sec_n = bcd_inc(regs_q[`RTC_SEC], `RTC_SEC_LAST, 8'h00);
        min_n = bcd_inc(regs_q[`RTC_MIN], `RTC_SEC_LAST, 8'h00);
        hour_n = bcd_inc(regs_q[`RTC_HOUR], `RTC_HOUR_LAST, 8'h00);
        day_n = bcd_inc(regs_q[`RTC_DAY],
                        month_len(regs_q[`RTC_MON], regs_q[`RTC_YEAR]),
                        `RTC_FIRST_ONE);
        wday_n = bcd_inc(regs_q[`RTC_WDAY], `RTC_WDAY_LAST, 8'h00);
        mon_n = bcd_inc(regs_q[`RTC_MON], `RTC_MON_LAST, `RTC_FIRST_ONE);
        year_n = bcd_inc(regs_q[`RTC_YEAR], `RTC_YEAR_LAST, 8'h00);
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tick_pend_q <= 1'b0;
        else if (tick_1hz && xfer_active_i)
            tick_pend_q <= 1'b1;
        else if (!xfer_active_i)
            tick_pend_q <= 1'b0;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < 64; i++)
                regs_q[i] <= `RTC_RST_VAL;
        end
        else
        begin
            // decode and mask
            // Upper pages would alias the low store
            if (do_wr && addr_q[7:6] == 2'b00)
                regs_q[addr_q[5:0]] <= wr_data_i & impl_mask(addr_q);
            if (advance)
            begin
                regs_q[`RTC_SEC] <= sec_n[7:0];
                if (sec_n[8])
                begin
                    regs_q[`RTC_MIN] <= min_n[7:0];
                    if (min_n[8])
                    begin
                        regs_q[`RTC_HOUR] <= hour_n[7:0];
                        if (hour_n[8])
                        begin
                            regs_q[`RTC_WDAY] <= wday_n[7:0];
                            regs_q[`RTC_DAY] <= day_n[7:0];
                            if (day_n[8])
                            begin
                                regs_q[`RTC_MON] <= mon_n[7:0];
                                if (mon_n[8])
                                    regs_q[`RTC_YEAR] <= year_n[7:0];
                            end
                        end
                    end
                end
            end
            // Set wins over a host clear in the same cycle
            if (tmr_zero)
                regs_q[`RTC_IRQ_FLAG][`RTC_B_TF] <= 1'b1;
        end
    end

    // ----------------------------------------
    // Countdown timer
    // ----------------------------------------
    // plain binary count
    logic [15:0] tmr_q;
    logic tmr_tick;
    tick_src_t tsrc;

    assign tsrc = tick_src_t'({ctrl[`RTC_B_TSRC_HI], ctrl[`RTC_B_TSRC_LO]});

    always_comb
    begin
        case (tsrc)
            SRC_32K: tmr_tick = base_tick;
            SRC_1K: tmr_tick = tick_1k;
            SRC_32: tmr_tick = tick_32;
            SRC_1HZ: tmr_tick = tick_1hz;
            default: tmr_tick = 1'b0;
        endcase
    end

    assign tmr_zero = ctrl[`RTC_B_TMR_EN] && tmr_tick
                      && tmr_q == 16'h0001;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tmr_q <= 16'h0000;
        else if (do_wr && addr_q[5:0] == `RTC_TMR_LO && addr_q[7:6] == 2'b00)
            tmr_q <= {tmr_q[15:8], wr_data_i};
        else if (do_wr && addr_q[5:0] == `RTC_TMR_HI && addr_q[7:6] == 2'b00)
            tmr_q <= {wr_data_i, tmr_q[7:0]};
        else if (tmr_zero)
        begin
            if (ctrl[`RTC_B_TMR_AR])
                tmr_q <= {regs_q[`RTC_TMR_HI], regs_q[`RTC_TMR_LO]};
            else
                tmr_q <= 16'h0000;
        end
        else if (ctrl[`RTC_B_TMR_EN] && tmr_tick && tmr_q != 16'h0000)
            tmr_q <= tmr_q - 16'h0001;
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [7:0] rd_val;

    always_comb
    begin
        case (addr_q[5:0])
            `RTC_TMR_LO: rd_val = tmr_q[7:0];
            `RTC_TMR_HI: rd_val = tmr_q[15:8];
            `RTC_TEMP: rd_val = temperature_i;
            default: rd_val = regs_q[addr_q[5:0]];
        endcase
        rd_val = rd_val & impl_mask(addr_q);
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rd_valid_o <= do_rd;
            if (do_rd)
                rd_data_o <= rd_val;
        end
    end

    // ----------------------------------------
    // Pin routing and control outputs
    // ----------------------------------------
    logic wave_q;
    logic fast_q;
    logic irq_active;
    logic [1:0] fsel;

    assign fsel = {regs_q[`RTC_NV_CTRL][`RTC_B_FD_HI],
                   regs_q[`RTC_NV_CTRL][`RTC_B_FD_LO]};
    assign irq_active = |(regs_q[`RTC_IRQ_FLAG] & regs_q[`RTC_IRQ_EN]);

    // Square waves taken from prescaler bits or the base-tick toggle flop, so duty stays at half
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            fast_q <= 1'b0;
            wave_q <= 1'b0;
        end
        else
        begin
            if (base_tick)
                fast_q <= !fast_q;
            case (tick_src_t'(fsel))
                SRC_32K: wave_q <= fast_q;
                SRC_1K: wave_q <= pre_q[4];
                SRC_32: wave_q <= pre_q[9];
                SRC_1HZ: wave_q <= pre_q[14];
                default: wave_q <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            clock_output_pin_o <= 1'b0;
            clock_output_pin_oe_o <= 1'b0;
        end
        else if (ctrl[`RTC_B_PINSEL])
        begin
            clock_output_pin_o <= wave_q;
            clock_output_pin_oe_o <= clock_output_pin_enable_i;
        end
        else
        begin
            clock_output_pin_o <= 1'b0;
            clock_output_pin_oe_o <= irq_active;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            self_recovery_enable_o <= 1'b0;
            nv_refresh_o <= 1'b0;
        end
        else
        begin
            self_recovery_enable_o <= ctrl[`RTC_B_SELFREC];
            nv_refresh_o <= ctrl[`RTC_B_NV_REF] && advance
                            && sec_n[8] && min_n[8];
        end
    end

endmodule : rtc_paged_register_map

// *** rtc_map_chk.sv ***
// Port-level assertions for the paged register map.
// Assumes a bind from the bench top with BASE_DIV handed on.
`timescale 1ns/1ps
module rtc_map_chk #(
    parameter int BASE_DIV = 2
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic xfer_active_i,
    input wire logic addr_valid_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_valid_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_req_i,
    input wire logic [7:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic [7:0] temperature_i,
    input wire logic clock_output_pin_enable_i,
    input wire logic clock_output_pin_o,
    input wire logic clock_output_pin_oe_o,
    input wire logic self_recovery_enable_o,
    input wire logic nv_refresh_o
);
    logic active_q;
    logic seen_q;
    logic [7:0] ptr_q;
    logic [7:0] ctrl_q;
    wire acc = xfer_active_i && seen_q;
    wire take = xfer_active_i && active_q && addr_valid_i && !seen_q;

    // ----------------------------------------
    // Shadow of the frame pointer and main control
    // ----------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            active_q <= 1'b0;
            seen_q <= 1'b0;
            ptr_q <= 8'h00;
            ctrl_q <= 8'h00;
        end
        else
        begin
            active_q <= xfer_active_i;
            seen_q <= xfer_active_i && (seen_q || take);
            if (take)
                ptr_q <= addr_i;
            else if (acc && (wr_valid_i || rd_req_i))
                ptr_q <= {ptr_q[7:3], ptr_q[2:0] + 3'h1};
            if (acc && wr_valid_i && ptr_q == 8'h00)
                ctrl_q <= wr_data_i;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_read;
        acc && rd_req_i;
    endsequence
    sequence s_ctrl_wr;
        acc && wr_valid_i && ptr_q == 8'h00;
    endsequence

    chk_read_answer: assert property (
        s_read |=> rd_valid_o) else $error("read not answered");
    chk_no_spurious: assert property (
        !(acc && rd_req_i) |=> !rd_valid_o) else $error("stray read valid");
    chk_unmapped_zero: assert property (
        s_read ##0 (ptr_q[7:6] != 2'b00 ||
        (ptr_q[7:3] == 5'h00 && ptr_q[2:0] > 3'h4))
        |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
    chk_weekday_bits: assert property (
        s_read ##0 ptr_q == 8'h0c |=> rd_data_o[7:3] == 5'h00)
        else $error("weekday spare bits set");
    chk_seconds_bit: assert property (
        s_read ##0 ptr_q == 8'h08 |=> !rd_data_o[7])
        else $error("seconds bit 7 set");
    chk_temp_value: assert property (
        s_read ##0 ptr_q == 8'h20 |=> rd_data_o == $past(temperature_i))
        else $error("thermometer read wrong");
    chk_srec_follow: assert property (
        s_ctrl_wr |-> ##2 self_recovery_enable_o == ctrl_q[4])
        else $error("self recovery output wrong");
    chk_pin_clock: assert property (
        s_ctrl_wr ##0 wr_data_i[7]
        |-> ##2 clock_output_pin_oe_o == clock_output_pin_enable_i)
        else $error("clock mode drive wrong");
    chk_int_pin_low: assert property (
        !ctrl_q[7] && !$past(ctrl_q[7]) |-> !clock_output_pin_o)
        else $error("pin data high in interrupt mode");
    chk_nv_quiet: assert property (
        !ctrl_q[3] && !$past(ctrl_q[3]) |-> !nv_refresh_o)
        else $error("refresh while disabled");
    chk_nv_pulse: assert property (
        nv_refresh_o |=> !nv_refresh_o) else $error("refresh not a pulse");
endmodule : rtc_map_chk

// *** rtc_host_model.sv ***
// Host model: frames, address byte, write and read strobes.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module rtc_host_model (
    input wire logic clock_i,
    output logic xfer_active_o,
    output logic addr_valid_o,
    output logic [7:0] addr_o,
    output logic wr_valid_o,
    output logic [7:0] wr_data_o,
    output logic rd_req_o
);
    initial
    begin
        xfer_active_o = 1'b0;
        addr_valid_o = 1'b0;
        addr_o = 8'h00;
        wr_valid_o = 1'b0;
        wr_data_o = 8'h00;
        rd_req_o = 1'b0;
    end

    // ----------------------------------------
    // One cycle on the byte port
    // ----------------------------------------
    // Idle lanes toggle so a stale byte never looks valid
    task automatic drive(input logic av, input logic wv, input logic rq,
                         input logic [7:0] d);
        addr_valid_o <= av;
        wr_valid_o <= wv;
        rd_req_o <= rq;
        addr_o <= av ? d : ~addr_o;
        wr_data_o <= wv ? d : ~wr_data_o;
        @(posedge clock_i);
    endtask : drive

    task automatic open_frame(input logic [7:0] a);
        xfer_active_o <= 1'b1;
        drive(1'b0, 1'b0, 1'b0, 8'h00);
        drive(1'b1, 1'b0, 1'b0, a);
    endtask : open_frame

    task automatic put_byte(input logic [7:0] d);
        drive(1'b0, 1'b1, 1'b0, d);
    endtask : put_byte

    task automatic get_byte();
        drive(1'b0, 1'b0, 1'b1, 8'h00);
    endtask : get_byte

    task automatic close_frame();
        xfer_active_o <= 1'b0;
        drive(1'b0, 1'b0, 1'b0, 8'h00);
        drive(1'b0, 1'b0, 1'b0, 8'h00);
    endtask : close_frame
endmodule : rtc_host_model

// *** test_rtc_paged_register_map.sv ***
// Self-checking bench for the paged register map behind a host model.
// Assumes BASE_DIV = 2, so one watch second is 65536 clocks.
`timescale 1ns/1ps
`define CHECK(got, exp, what) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("CHECK FAILED %0t %s %h/%h", $time, what, got, exp); \
        end \
    end

module test_rtc_paged_register_map;
    localparam int BASE_DIV = 2;
    logic clock_i;
    logic resetn_i;
    logic xfer_active, addr_valid, wr_valid, rd_req, rd_valid;
    logic [7:0] addr, wr_data, rd_data, e, r, temperature;
    logic clk_en, pin, pin_oe, self_rec, nv_refresh;
    int err_total = 0;
    int n_compared = 0;
    int nv_seen = 0;
    logic [7:0] exp_q[$];
    logic [7:0] map_a[21] = '{8'h01, 8'h02, 8'h08, 8'h09, 8'h0b, 8'h0c,
        8'h0d, 8'h0e, 8'h10, 8'h12, 8'h14, 8'h15, 8'h19, 8'h29, 8'h31,
        8'h33, 8'h3a, 8'h05, 8'h17, 8'h40, 8'hc8};
    logic [7:0] map_m[21] = '{8'h1f, 8'h1f, 8'h7f, 8'h7f, 8'h3f, 8'h07,
        8'h1f, 8'h7f, 8'hff, 8'hbf, 8'h87, 8'h9f, 8'hff, 8'hff, 8'hff,
        8'h3f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

    rtc_host_model i_host (.clock_i(clock_i), .xfer_active_o(xfer_active),
        .addr_valid_o(addr_valid), .addr_o(addr), .wr_valid_o(wr_valid),
        .wr_data_o(wr_data), .rd_req_o(rd_req));

    rtc_paged_register_map #(.BASE_DIV(BASE_DIV)) i_dut (.clock_i(clock_i),
        .resetn_i(resetn_i), .xfer_active_i(xfer_active),
        .addr_valid_i(addr_valid), .addr_i(addr), .wr_valid_i(wr_valid),
        .wr_data_i(wr_data), .rd_req_i(rd_req), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .temperature_i(temperature),
        .clock_output_pin_enable_i(clk_en), .clock_output_pin_o(pin),
        .clock_output_pin_oe_o(pin_oe), .self_recovery_enable_o(self_rec),
        .nv_refresh_o(nv_refresh));

    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // ----------------------------------------
    // Result watcher and closing
    // ----------------------------------------
    always @(negedge clock_i)
    begin
        if (rd_valid === 1'b1)
        begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `CHECK(rd_data, e, "read data")
        end
        if (nv_refresh === 1'b1)
            nv_seen++;
    end

    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (90000) @(posedge clock_i);
        `CHECK(1'b0, 1'b1, "watchdog expired")
        end_of_test();
    end

    task automatic rd_exp(input logic [7:0] x);
        exp_q.push_back(x);
        i_host.get_byte();
    endtask : rd_exp

    task automatic wr1(input logic [7:0] a, input logic [7:0] d);
        i_host.open_frame(a);
        i_host.put_byte(d);
        i_host.close_frame();
    endtask : wr1

    task automatic rd1(input logic [7:0] a, input logic [7:0] x);
        i_host.open_frame(a);
        rd_exp(x);
        i_host.close_frame();
    endtask : rd1

    // Pins are looked at off the edge, then the bench resyncs
    task automatic pins(input logic sr, input logic oe);
        repeat (3) @(posedge clock_i);
        #1;
        `CHECK(self_rec, sr, "self recovery")
        `CHECK(pin_oe, oe, "pin drive")
        @(posedge clock_i);
    endtask : pins

    initial
    begin
        resetn_i = 1'b0;
        temperature = 8'h00;
        clk_en = 1'b0;
        r = 8'($urandom(32'h6757671f));
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        temperature <= 8'($urandom);
        @(posedge clock_i);
        i_host.open_frame(8'h00);
        repeat (5) rd_exp(8'h00);
        i_host.close_frame();
        `CHECK({self_rec, pin_oe, pin}, 3'b000, "reset pins")
        $display("Test reset values done");
        foreach (map_a[i])
        begin
            r = 8'($urandom);
            wr1(map_a[i], r);
            rd1(map_a[i], r & map_m[i]);
        end
        wr1(8'h08, 8'h11);
        wr1(8'hc8, 8'h00);
        rd1(8'h08, 8'h11);
        wr1(8'h20, ~temperature);
        rd1(8'h20, temperature);
        $display("Test bit masks done");
        i_host.open_frame(8'h3e);
        for (int k = 0; k < 3; k++)
            i_host.put_byte(8'ha0 + 8'(k));
        i_host.close_frame();
        i_host.open_frame(8'h3e);
        for (int k = 0; k < 4; k++)
            rd_exp(k < 3 ? 8'ha0 + 8'(k) : 8'h00);
        i_host.close_frame();
        $display("Test page wrap done");
        clk_en <= 1'b1;
        i_host.open_frame(8'h00);
        i_host.put_byte(8'h90);
        i_host.put_byte(8'h00);
        i_host.put_byte(8'h00);
        i_host.close_frame();
        pins(1'b1, 1'b1);
        repeat (4) @(negedge clock_i) r = {r[6:0], pin};
        @(posedge clock_i);
        `CHECK($countones(r[3:0]), 2, "clock wave")
        clk_en <= 1'b0;
        pins(1'b1, 1'b0);
        for (int s = 0; s < 4; s++)
        begin
            wr1(8'h00, {1'b0, 2'(s), 5'h08});
            rd1(8'h00, {1'b0, 2'(s), 5'h08});
        end
        pins(1'b0, 1'b0);
        $display("Test control bits done");
        wr1(8'h01, 8'h02);
        i_host.open_frame(8'h18);
        i_host.put_byte(8'h05);
        i_host.put_byte(8'h00);
        i_host.close_frame();
        wr1(8'h00, 8'h02);
        repeat (40) i_host.drive(1'b0, 1'b0, 1'b0, 8'h00);
        rd1(8'h18, 8'h00);
        rd1(8'h02, 8'h02);
        pins(1'b0, 1'b1);
        wr1(8'h02, 8'h00);
        pins(1'b0, 1'b0);
        wr1(8'h00, 8'h06);
        wr1(8'h18, 8'h01);
        repeat (8) i_host.drive(1'b0, 1'b0, 1'b0, 8'h00);
        rd1(8'h18, 8'h01);
        $display("Test countdown done");
        i_host.open_frame(8'h08);
        i_host.put_byte(8'h59);
        i_host.put_byte(8'h59);
        i_host.put_byte(8'h22);
        i_host.close_frame();
        wr1(8'h00, 8'h09);
        i_host.open_frame(8'h08);
        repeat (70000) i_host.drive(1'b0, 1'b0, 1'b0, 8'h00);
        rd_exp(8'h59);
        i_host.close_frame();
        i_host.open_frame(8'h08);
        rd_exp(8'h00);
        rd_exp(8'h00);
        rd_exp(8'h23);
        i_host.close_frame();
        `CHECK(nv_seen, 1, "hourly refresh")
        $display("Test watch advance done");
        end_of_test();
    end
endmodule : test_rtc_paged_register_map

bind test_rtc_paged_register_map rtc_map_chk #(.BASE_DIV(BASE_DIV)) i_chk (
    .clock_i(clock_i), .resetn_i(resetn_i), .xfer_active_i(xfer_active),
    .addr_valid_i(addr_valid), .addr_i(addr), .wr_valid_i(wr_valid),
    .wr_data_i(wr_data), .rd_req_i(rd_req), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .temperature_i(temperature),
    .clock_output_pin_enable_i(clk_en), .clock_output_pin_o(pin),
    .clock_output_pin_oe_o(pin_oe), .self_recovery_enable_o(self_rec),
    .nv_refresh_o(nv_refresh));
